// >>> rtl/tws_params.svh
// Register offsets, field positions, reset values and counts of the two-wire serial channel.
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH
`define TWS_ADDR_MODE     16'hFF60
`define TWS_ADDR_BUSLINE  16'hFF61
`define TWS_ADDR_SHIFT    16'hFF62
`define TWS_ADDR_SLAVE    16'hFF63
`define TWS_ADDR_TIMING   16'hFF64
`define TWS_BIT_ENABLE    7
`define TWS_BIT_MATCH     6
`define TWS_BIT_WAKE      5
`define TWS_BIT_MODE_HI   4
`define TWS_BIT_MODE_MID  3
`define TWS_BIT_MODE_LO   2
`define TWS_BIT_CLK_HI    1
`define TWS_BIT_CLK_LO    0
`define TWS_BIT_RELEASE   0
`define TWS_BIT_COMMAND   1
`define TWS_BIT_CLK_LEVEL 6
`define TWS_RESET_BYTE    8'h00
`define TWS_HALF_EDGES    5'h10
`endif

// >>> rtl/tws_pkg.sv
// Types shared by the two-wire serial channel modules.
package tws_pkg;
  // Transfer sequencer states, Gray coded along idle, run, drain.
  typedef enum logic [1:0] {
    TWS_IDLE  = 2'b00,
    TWS_RUN   = 2'b01,
    TWS_DRAIN = 2'b11
  } tws_state_type;

  // All state of the system-clock side.
  typedef struct packed {
    tws_state_type state;
    logic [7:0]    mode;
    logic [7:0]    busline;
    logic [7:0]    timing;
    logic [7:0]    shift;
    logic [7:0]    slave;
    logic          so_latch;
    logic          int_sck;
    logic [4:0]    half;
    logic          irq;
    logic [7:0]    rdata;
    logic          sck_s1;
    logic          sck_s2;
    logic          done_s1;
    logic          done_s2;
    logic          done_seen;
  } tws_sys_type;

  // State of the link side clocked on the rising serial clock edge.
  typedef struct packed {
    logic [2:0] rcnt;
    logic [7:0] rx;
    logic       done_tgl;
  } tws_link_type;
endpackage : tws_pkg

// >>> rtl/tws_link_if.sv
// Carrier between the system-side control and the link-side shifter.
`timescale 1ns/100ps
interface tws_link_if;
  logic [7:0] tx_word;  // Byte to send, held stable during a transfer.
  logic       data_in;  // Selected data line level.
  logic [7:0] rx_word;  // Byte captured from the line.
  logic       out_bit;  // Bit currently driven during a transfer.
  logic       done_tgl; // Flips once per completed byte.
  modport sys (output tx_word, output data_in, input rx_word, input out_bit, input done_tgl);
  modport shf (input tx_word, input data_in, output rx_word, output out_bit, output done_tgl);
endinterface : tws_link_if

// >>> rtl/tws_shifter.sv
// Link-side shifter of the two-wire serial channel, clocked by the serial clock.
`timescale 1ns/100ps
module tws_shifter
  import tws_pkg::*;
(
  // Link clock and reset.
  input  wire logic clk_link,
  input  wire logic reset_n,
  // Carrier toward the system side.
  tws_link_if.shf   lnk
);
  import tws_pkg::*;

  tws_link_type s_r;    // Rising-edge state.
  tws_link_type s_nxt;  // Its next value.
  logic [2:0]   fcnt_r; // Falling edges seen in this byte.
  logic         out_r;  // Bit launched on the last falling edge.

  // The clock only runs inside frames, so counts wrap at eight and need no edge after the last.
  always_comb begin
    s_nxt = s_r;
    s_nxt.rx = {s_r.rx[6:0], lnk.data_in};
    s_nxt.rcnt = s_r.rcnt + 3'h1;
    if (s_r.rcnt == 3'h7) begin
      s_nxt.done_tgl = ~s_r.done_tgl;
    end
  end

  // Rising edge captures the line.
  always_ff @(posedge clk_link or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Falling edge launches the next bit, most significant first.
  always_ff @(negedge clk_link or negedge reset_n) begin
    if (!reset_n) begin
      fcnt_r <= 3'h0;
      out_r  <= 1'b1;
    end else begin
      out_r  <= lnk.tx_word[3'h7 - fcnt_r];
      fcnt_r <= fcnt_r + 3'h1;
    end
  end

  assign lnk.rx_word  = s_r.rx;
  assign lnk.out_bit  = out_r;
  assign lnk.done_tgl = s_r.done_tgl;
endmodule : tws_shifter

// >>> rtl/tws_channel.sv
// Two-wire serial channel: registers, clock generation, sequencing and pins.
`timescale 1ns/100ps
`include "tws_params.svh"
module tws_channel
  import tws_pkg::*;
(
  // System clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Register access port.
  input  wire logic [15:0] cpu_addr,
  input  wire logic [7:0]  cpu_wdata,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rd,
  output logic      [7:0]  cpu_rdata,
  // Clock sources and port latch.
  input  wire logic        timer_two_output,
  input  wire logic        timer_clock_tick,
  input  wire logic        clock_port_latch,
  // Transfer completion flag.
  input  wire logic        irq_flag_clear,
  output logic             transfer_done_irq_flag,
  // Serial clock pin, as level and as link clock.
  input  wire logic        serial_clock_pin_clk,
  input  wire logic        serial_clock_pin_i,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe,
  // Open-drain data lines.
  input  wire logic        bus_data_line_a_i,
  output logic             bus_data_line_a_o,
  output logic             bus_data_line_a_oe,
  input  wire logic        bus_data_line_b_i,
  output logic             bus_data_line_b_o,
  output logic             bus_data_line_b_oe
);
  import tws_pkg::*;

  tws_sys_type s_r;   // All system-side state.
  tws_sys_type s_nxt; // Its next value.
  tws_link_if  lnk(); // Carrier to the shifter.

  logic enable;      // Channel enable bit.
  logic two_wire;    // Two-wire mode selected.
  logic use_line_a;  // Data on the line-a side pin.
  logic int_clock;   // Shift clock made inside.
  logic tick;        // Selected internal clock tick.
  logic match;       // Address comparison result.
  logic clk_level;   // Clock pin level flag.
  logic done_evt;    // A byte finished on the link.
  logic busy;        // A transfer is in progress.
  logic sck_level;   // Level the clock pin aims at.
  logic data_level;  // Level the data line aims at.
  logic wr_mode;     // Write strobes per register.
  logic wr_busline;
  logic wr_shift;
  logic wr_slave;
  logic wr_timing;
  logic set_irq;     // Completion sets the flag.

  // Decode of the mode register and derived conditions.
  always_comb begin
    enable     = s_r.mode[`TWS_BIT_ENABLE];
    two_wire   = s_r.mode[`TWS_BIT_MODE_HI] & s_r.mode[`TWS_BIT_MODE_MID];
    use_line_a = s_r.mode[`TWS_BIT_MODE_LO];
    int_clock  = s_r.mode[`TWS_BIT_CLK_HI];
    tick       = s_r.mode[`TWS_BIT_CLK_LO] ? timer_clock_tick : timer_two_output;
    match      = enable & (s_r.slave == s_r.shift);
    clk_level  = enable & s_r.sck_s2;
    done_evt   = s_r.done_s2 ^ s_r.done_seen;
    busy       = (s_r.state != TWS_IDLE);
  end

  // Register write strobes.
  always_comb begin
    wr_mode    = cpu_wr & (cpu_addr == `TWS_ADDR_MODE);
    wr_busline = cpu_wr & (cpu_addr == `TWS_ADDR_BUSLINE);
    wr_shift   = cpu_wr & (cpu_addr == `TWS_ADDR_SHIFT);
    wr_slave   = cpu_wr & (cpu_addr == `TWS_ADDR_SLAVE);
    wr_timing  = cpu_wr & (cpu_addr == `TWS_ADDR_TIMING);
  end

  // Next-state logic of the whole system side.
  always_comb begin
    s_nxt = s_r;
    set_irq = 1'b0;
    // The first flop of each synchroniser feeds only the second.
    s_nxt.sck_s1    = serial_clock_pin_i;
    s_nxt.sck_s2    = s_r.sck_s1;
    s_nxt.done_s1   = lnk.done_tgl;
    s_nxt.done_s2   = s_r.done_s1;
    s_nxt.done_seen = s_r.done_s2;

    // Mode register keeps the read-only flag position at zero.
    if (wr_mode) begin
      s_nxt.mode = cpu_wdata;
      s_nxt.mode[`TWS_BIT_MATCH] = 1'b0;
    end
    // Trigger bits act at once and never stay stored.
    if (wr_busline) begin
      s_nxt.busline = {cpu_wdata[7:2], 2'b00};
      if (enable && cpu_wdata[`TWS_BIT_RELEASE]) begin
        s_nxt.so_latch = 1'b1;
      end
      if (enable && cpu_wdata[`TWS_BIT_COMMAND]) begin
        s_nxt.so_latch = 1'b0;
      end
    end
    if (wr_timing) begin
      s_nxt.timing = cpu_wdata;
      s_nxt.timing[`TWS_BIT_CLK_LEVEL] = 1'b0;
    end
    if (wr_slave) begin
      s_nxt.slave = cpu_wdata;
    end
    // A byte is only accepted while idle, so the shifter sees a stable word.
    if (wr_shift && !busy) begin
      s_nxt.shift = cpu_wdata;
      // Start needs enable now; a write made while disabled stays inert.
      if (enable && (int_clock || s_r.sck_s2)) begin
        s_nxt.state   = TWS_RUN;
        s_nxt.half    = 5'h00;
        s_nxt.int_sck = 1'b1;
      end
    end

    // Transfer sequencer.
    case (s_r.state)
      TWS_IDLE: begin
        s_nxt.int_sck = 1'b1;
      end
      TWS_RUN: begin
        if (!int_clock) begin
          // External clock: the master drives all edges.
          s_nxt.state = TWS_DRAIN;
        end else if (tick) begin
          s_nxt.int_sck = ~s_r.int_sck;
          s_nxt.half    = s_r.half + 5'h01;
          if (s_r.half == (`TWS_HALF_EDGES - 5'h01)) begin
            s_nxt.state = TWS_DRAIN;
          end
        end
      end
      TWS_DRAIN: begin
        // Wait for the link to report the eighth rising edge.
        if (done_evt) begin
          s_nxt.state    = TWS_IDLE;
          s_nxt.shift    = lnk.rx_word;
          s_nxt.so_latch = lnk.out_bit;
          set_irq = ~s_r.mode[`TWS_BIT_WAKE] | ~two_wire | match;
        end
      end
      default: begin
        s_nxt.state = TWS_IDLE;
      end
    endcase

    // Disabling stops the sequencer at once; the internal clock returns high.
    if (!enable) begin
      s_nxt.state   = TWS_IDLE;
      s_nxt.int_sck = 1'b1;
    end
    // A completion in the same cycle as a clear wins.
    s_nxt.irq = set_irq | (s_r.irq & ~irq_flag_clear);

    // Registered read answer; unmapped addresses read zero.
    s_nxt.rdata = 8'h00;
    if (cpu_rd) begin
      case (cpu_addr)
        `TWS_ADDR_MODE: begin
          s_nxt.rdata = s_r.mode;
          s_nxt.rdata[`TWS_BIT_MATCH] = match;
        end
        `TWS_ADDR_BUSLINE: begin
          s_nxt.rdata = s_r.busline;
        end
        `TWS_ADDR_SHIFT: begin
          s_nxt.rdata = s_r.shift;
        end
        `TWS_ADDR_SLAVE: begin
          s_nxt.rdata = s_r.slave;
        end
        `TWS_ADDR_TIMING: begin
          s_nxt.rdata = s_r.timing;
          s_nxt.rdata[`TWS_BIT_CLK_LEVEL] = clk_level;
        end
        default: begin
          s_nxt.rdata = 8'h00;
        end
      endcase
    end
  end

  // State register; everything clears on reset.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Link side shifter on the serial clock.
  tws_shifter u_shifter (
    .clk_link (serial_clock_pin_clk),
    .reset_n  (reset_n),
    .lnk      (lnk.shf)
  );

  assign lnk.tx_word = s_r.shift;
  assign lnk.data_in = use_line_a ? bus_data_line_a_i : bus_data_line_b_i;

  // Pin drive. Open drain: only a low level is driven.
  always_comb begin
    // Idle internal clock follows the port latch for static levels.
    sck_level  = busy ? s_r.int_sck : clock_port_latch;
    data_level = busy ? lnk.out_bit : s_r.so_latch;
    serial_clock_pin_o  = 1'b0;
    serial_clock_pin_oe = two_wire & int_clock & ~sck_level;
    bus_data_line_a_o   = 1'b0;
    bus_data_line_a_oe  = two_wire & enable & use_line_a & ~data_level;
    bus_data_line_b_o   = 1'b0;
    bus_data_line_b_oe  = two_wire & enable & ~use_line_a & ~data_level;
  end

  assign cpu_rdata              = s_r.rdata;
  assign transfer_done_irq_flag = s_r.irq;

  // Checks on the system side.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_start_needs_enable: assert property (
    $rose(busy) |-> $past(enable) && $past(wr_shift))
    else $error("transfer started without enable");
  a_disable_stops: assert property (
    !enable |=> s_r.state == TWS_IDLE)
    else $error("transfer running while disabled");
  a_release_sets: assert property (
    wr_busline && enable && cpu_wdata[0] && !cpu_wdata[1] && !busy |=> s_r.so_latch)
    else $error("release trigger did not set latch");
  a_command_clears: assert property (
    wr_busline && enable && cpu_wdata[1] && !busy |=> !s_r.so_latch)
    else $error("command trigger did not clear latch");
  a_trigger_zero: assert property (
    s_r.busline[1:0] == 2'b00)
    else $error("trigger bit stayed set");
  a_match_read: assert property (
    cpu_rd && cpu_addr == `TWS_ADDR_MODE |=> cpu_rdata[6] == $past(match))
    else $error("comparison flag read wrong");
  a_level_disabled: assert property (
    cpu_rd && cpu_addr == `TWS_ADDR_TIMING && !enable |=> !cpu_rdata[6])
    else $error("clock level flag set while disabled");
  a_done_sets_irq: assert property (
    s_r.state == TWS_DRAIN && done_evt && !s_r.mode[5] && enable |=> transfer_done_irq_flag)
    else $error("completion flag not set");
  a_clock_idle_high: assert property (
    int_clock && $fell(busy) |-> s_r.int_sck ##1 s_r.int_sck)
    else $error("serial clock not idle high");
  a_sixteen_edges: assert property (
    s_r.state == TWS_RUN |-> s_r.half < `TWS_HALF_EDGES)
    else $error("too many clock half periods");

  c_internal_xfer: cover property (int_clock && s_r.state == TWS_DRAIN && done_evt);
  c_external_xfer: cover property (!int_clock && s_r.state == TWS_DRAIN && done_evt);
  c_release_write: cover property (wr_busline && enable && cpu_wdata[0]);
  c_match_seen:    cover property (match && $fell(busy));
endmodule : tws_channel

// >>> dv/tws_far_end.sv
// Far-side bus partner that clocks byte frames and drives the shared data line.
`timescale 1ns/100ps
module tws_far_end (
  // Frame request and byte to send.
  input  wire logic       go,
  input  wire logic [7:0] tx,
  // Resolved data wire.
  input  wire logic       sda,
  // Open-drain drives, high pulls the wire low.
  output logic            sck_oe,
  output logic            sda_oe,
  output logic      [7:0] rx
);
  // Clock stands high between frames, so the channel never sees stray edges.
  // One process owns every output, so each signal has a single driver.
  initial begin
    sck_oe = 1'b0;
    sda_oe = 1'b0;
    rx     = 8'h00;
    // A 30 ns clock runs only inside the frame; data changes after each fall.
    forever begin
      @(posedge go);
      for (int i = 7; i >= 0; i--) begin
        #15 sck_oe = 1'b1;
        sda_oe = !tx[i];
        #15 sck_oe = 1'b0;
        rx = {rx[6:0], sda};
      end
      #15 sda_oe = 1'b0;
    end
  end
endmodule : tws_far_end

// >>> dv/testbench.sv
// Self-checking bench of the two-wire serial channel.
`timescale 1ns/100ps
module testbench;
  logic        clk_sys, reset_n, wr, rd, t2, tck, port, clr, go;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, ftx, frx;
  logic        irq, sck_oe, a_oe, b_oe, f_sck, f_sda, sck_o, a_o, b_o;
  int          miscompares, n_tests, cyc, nfall;
  // Wires are pulled up unless some party drives low.
  wire sck_w = !(sck_oe | f_sck);
  wire a_w   = !a_oe;
  wire b_w   = !(b_oe | f_sda);
  tws_channel tws_channel_i (.clk_sys(clk_sys), .reset_n(reset_n), .cpu_addr(addr),
    .cpu_wdata(wdata), .cpu_wr(wr), .cpu_rd(rd), .cpu_rdata(rdata),
    .timer_two_output(t2), .timer_clock_tick(tck), .clock_port_latch(port),
    .irq_flag_clear(clr), .transfer_done_irq_flag(irq), .serial_clock_pin_clk(sck_w),
    .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o), .serial_clock_pin_oe(sck_oe),
    .bus_data_line_a_i(a_w), .bus_data_line_a_o(a_o), .bus_data_line_a_oe(a_oe),
    .bus_data_line_b_i(b_w), .bus_data_line_b_o(b_o), .bus_data_line_b_oe(b_oe));
  tws_far_end tws_far_end_i (.go(go), .tx(ftx), .sda(b_w), .sck_oe(f_sck),
    .sda_oe(f_sda), .rx(frx));
  // System clock at 20 MHz.
  always #25 clk_sys = !clk_sys;
  // Falling serial clock edges are counted to check the frame length.
  always @(negedge sck_w) nfall++;
  // Cuts a hang short; the whole run needs only a few hundred cycles.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  // Compares one value and reports a mismatch at once.
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // One-cycle write strobe, launched at the falling edge.
  task wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys) {addr, wdata, wr} = {a, d, 1'b1};
    @(negedge clk_sys) wr = 1'b0;
  endtask : wr_reg
  // Read data stands for the one cycle after the strobe edge.
  task rd_reg(input logic [15:0] a, input logic [7:0] exp);
    @(negedge clk_sys) {addr, rd} = {a, 1'b1};
    @(negedge clk_sys) rd = 1'b0;
    check(rdata, exp);
  endtask : rd_reg
  // Waits a bounded time for completion, then clears the flag.
  task wait_done;
    for (int i = 0; i < 400 && irq !== 1'b1; i++) @(negedge clk_sys);
    check({7'h00, irq}, 8'h01);
    @(negedge clk_sys) clr = 1'b1;
    @(negedge clk_sys) clr = 1'b0;
    check({7'h00, irq}, 8'h00);
  endtask : wait_done
  // Loads the shift register, lets the far end clock one frame.
  task xfer(input logic [7:0] d, input logic [7:0] f);
    wr_reg(16'hFF62, d);
    repeat (4) @(negedge clk_sys);
    {ftx, go} = {f, 1'b1};
    @(negedge clk_sys) go = 1'b0;
    wait_done();
  endtask : xfer
  // Prints the counts and the verdict, then ends the run.
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  // Main sequence.
  initial begin
    {clk_sys, reset_n, wr, rd, t2, tck, port, clr, go} = 9'h000;
    {addr, wdata, ftx, miscompares, n_tests, cyc, nfall} = '0;
    repeat (4) @(negedge clk_sys);
    reset_n = 1'b1;
    rd_reg(16'hFF60, 8'h00);
    rd_reg(16'hFF61, 8'h00);
    rd_reg(16'hFF70, 8'h00);
    wr_reg(16'hFF63, 8'h55);
    wr_reg(16'hFF60, 8'hD8);
    rd_reg(16'hFF60, 8'h98);
    wr_reg(16'hFF61, 8'h02);
    check({7'h00, b_oe}, 8'h01);
    rd_reg(16'hFF61, 8'h00);
    wr_reg(16'hFF61, 8'h01);
    check({6'h00, a_oe, b_oe}, 8'h00);
    xfer(8'hFF, 8'hA5);
    rd_reg(16'hFF62, 8'hA5);
    check(frx, 8'hA5);
    xfer(8'h3C, 8'hFF);
    check(frx, 8'h3C);
    wr_reg(16'hFF63, 8'h3C);
    rd_reg(16'hFF60, 8'hD8);
    wr_reg(16'hFF60, 8'h9C);
    wr_reg(16'hFF61, 8'h02);
    check({6'h00, a_oe, b_oe}, 8'h02);
    wr_reg(16'hFF61, 8'h01);
    wr_reg(16'hFF60, 8'h18);
    rd_reg(16'hFF60, 8'h18);
    wr_reg(16'hFF64, 8'h40);
    rd_reg(16'hFF64, 8'h00);
    wr_reg(16'hFF61, 8'h02);
    check({6'h00, a_oe, b_oe}, 8'h00);
    wr_reg(16'hFF62, 8'h11);
    wr_reg(16'hFF60, 8'h98);
    repeat (20) @(negedge clk_sys);
    check({7'h00, irq}, 8'h00);
    rd_reg(16'hFF62, 8'h11);
    // Internal clock from timer two, then from the prescaler.
    port = 1'b1;
    for (int s = 2; s < 4; s++) begin
      wr_reg(16'hFF60, 8'h98 | s[7:0]);
      nfall = 0;
      wr_reg(16'hFF62, 8'hFF);
      wr_reg(16'hFF62, 8'h00);
      repeat (16) begin
        @(negedge clk_sys) {t2, tck} = (s == 2) ? 2'b10 : 2'b01;
        @(negedge clk_sys) {t2, tck} = 2'b00;
        repeat (2) @(negedge clk_sys);
      end
      wait_done();
      check(nfall[7:0], 8'h08);
      check({7'h00, sck_w}, 8'h01);
      rd_reg(16'hFF62, 8'hFF);
    end
    @(negedge clk_sys) port = 1'b0;
    repeat (2) @(negedge clk_sys);
    check({7'h00, sck_w}, 8'h00);
    // Open-drain pins only ever drive low, so their data outputs stay zero.
    check({5'h00, sck_o, a_o, b_o}, 8'h00);
    final_report();
  end
endmodule : testbench
